/* rtl/stm_pkg.sv */
// Package for the standard timer mode logic: mode codes, pin-function codes, reset values.
package stm_pkg;
  localparam int STM_CNT_W = 16;
  localparam int STM_COMPARE_P_VALUE_W = 8;
  localparam int STM_COMPARE_P_VALUE_LSB = 8;
  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_CAP = 2'h1;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TMR = 2'h3;
  localparam logic [1:0] STM_PF_INACT = 2'h0;
  localparam logic [1:0] STM_PF_ACT = 2'h1;
  localparam logic [1:0] STM_PF_PWM = 2'h2;
  localparam logic [1:0] STM_PF_SPULSE = 2'h3;
  localparam logic [1:0] STM_PF_CAP_RISE = 2'h0;
  localparam logic [1:0] STM_PF_CAP_FALL = 2'h1;
  localparam logic [1:0] STM_PF_CAP_BOTH = 2'h2;
  localparam logic [1:0] STM_PF_CAP_OFF = 2'h3;
  localparam logic [15:0] STM_CNT_RST = 16'h0000;
  localparam logic [15:0] STM_COMPARE_A_VALUE_RST = 16'h0000;
  localparam logic [15:0] STM_CNT_MAX = 16'hffff;

  // Control bits of the timer control register
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_function;
    logic       output_level_ctrl;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_source_select;
  } stm_ctrl_t;
endpackage

/* rtl/stm_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge detect for one pin.
`timescale 1ns/1ns
module stm_edge_sync
  import stm_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic       meta;
  logic       sync;
  logic       prev;
  logic [2:0] fill;

  // First flop feeds only the second one
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      fill <= 3'h0;
    end
    else
    begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
      fill <= {fill[1:0], 1'b1};
    end
  end

  // Edges seen in the same cycle the synchronised level moves
  // Held off until the pipe holds real pin samples, so an idle-high pin gives no false edge
  assign level_out = sync;
  assign rise_out  = fill[2] & sync & ~prev;
  assign fall_out  = fill[2] & ~sync & prev;
endmodule

/* rtl/stm_timer.sv */
// Standard timer: compare, timer/counter, PWM, single pulse and capture modes.
//
// Overview of operation
// - With clear on compare A in compare mode, never set the P flag.
// - Mode 11 counts, clears and flags exactly like compare-match mode.
// - Timer/counter mode leaves the output pin undriven.
// - PWM ignores clear select; swap bit picks period and duty registers.
// - Swap clear: period is P times 256 (zero means 65536), duty A.
// - Swap set: period is A, duty is P times 256 (zero 65536).
// - Duty at or above period holds the output active all period.
// - PWM sets a flag on each A match and each P match.
// - Level control picks PWM polarity; pin function enables or forces.
// - Invert bit flips the final output level.
// - Counter and compares keep running while the output is forced.
// - Single pulse: trigger pin edge sets the run bit.
// - Single pulse: run bit rising starts counter and pulse.
// - Single pulse: A match clears run, ends pulse, flags; clear ends too.
// - Single pulse: counter zeroed only on run rising; P, swap ignored.
// - Mode 01 is capture; counter starts on run bit rising.
// - Selected capture edge copies counter into compare A, raises flag.
// - Capture: counter free runs until run falls; P match zeroes it.
// - Capture: every P match raises the timer flag too.
// - Capture pin function 11 disables captures, counter keeps running.
// - Capture edge select: 00 rising, 01 falling, 10 both, 11 off.
// - Compare P meets counter bits 15 to 8, 256-clock steps.
// - Run bit rising clears counter; outside PWM mode it also restores initial output level.
`timescale 1ns/1ns
module stm_timer
  import stm_pkg::*;
#(
  parameter int CNT_W = STM_CNT_W
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire stm_ctrl_t   ctrl_in,
  input  wire logic        run_set_in,
  input  wire logic        run_clr_in,
  input  wire logic [15:0] compare_a_value_in,
  input  wire logic        compare_a_wr_in,
  input  wire logic [7:0]  compare_p_value_in,
  input  wire logic        flag_a_clr_in,
  input  wire logic        flag_p_clr_in,
  input  wire logic        ext_clock_trigger_pin_in,
  input  wire logic        capture_input_pin_in,
  output logic             counter_run_out,
  output logic [15:0]      counter_out,
  output logic [15:0]      compare_a_value_out,
  output logic             match_a_flag_out,
  output logic             match_p_flag_out,
  output logic             timer_out,
  output logic             timer_oe_n_out
);
  // Only the documented width is served by the compare-P alignment
  if (CNT_W != STM_CNT_W)
  begin : g_width_check
    $error("stm_timer: CNT_W must be 16");
  end

  logic        run;
  logic        run_prev;
  logic [15:0] cnt;
  logic [15:0] compare_a_value;
  logic        flag_a;
  logic        flag_p;
  logic        wave;
  logic        trig_rise;
  logic        cap_rise;
  logic        cap_fall;
  logic        run_rise;
  logic        match_a;
  logic        match_p;
  logic        counting;
  logic [15:0] a_last;
  logic [7:0]  p_last;
  logic        is_pwm;
  logic        is_spulse;
  logic        is_cap;
  logic        is_cmp;
  logic        capture;
  logic        period_hit;
  logic [16:0] duty_val;
  logic [16:0] period_val;
  logic [16:0] pos;
  logic        pwm_active;
  logic        active_lvl;
  logic        next_run;
  logic        next_out;

  // Pin synchronisers
  stm_edge_sync u_trig_sync
  (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (ext_clock_trigger_pin_in),
    .level_out  (),
    .rise_out   (trig_rise),
    .fall_out   ()
  );

  stm_edge_sync u_cap_sync
  (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (capture_input_pin_in),
    .level_out  (),
    .rise_out   (cap_rise),
    .fall_out   (cap_fall)
  );

  // Mode decode
  assign is_pwm    = (ctrl_in.mode_select == STM_MODE_PWM) && (ctrl_in.pin_function != STM_PF_SPULSE);
  assign is_spulse = (ctrl_in.mode_select == STM_MODE_PWM) && (ctrl_in.pin_function == STM_PF_SPULSE);
  assign is_cap    = (ctrl_in.mode_select == STM_MODE_CAP);
  assign is_cmp    = (ctrl_in.mode_select == STM_MODE_CMP) ||
                     (ctrl_in.mode_select == STM_MODE_TMR);
  assign run_rise  = run & ~run_prev;

  // Comparators look one count ahead, so a clear lands on the compare value
  // itself and the period equals the register, not one clock more
  // The run-rise cycle still shows the stale count, so matches wait a cycle
  assign counting = run & run_prev;
  assign a_last   = compare_a_value - 16'h0001;
  assign p_last   = compare_p_value_in - 8'h01; // P of zero wraps to a full 65536
  assign match_a  = counting && (cnt == a_last);
  assign match_p  = counting && (cnt[15:STM_COMPARE_P_VALUE_LSB] == p_last) && (cnt[7:0] == 8'hff);

  // Capture edge choice
  always_comb
  begin
    capture = 1'b0;
    unique case (ctrl_in.pin_function)
      STM_PF_CAP_RISE: capture = cap_rise;
      STM_PF_CAP_FALL: capture = cap_fall;
      STM_PF_CAP_BOTH: capture = cap_rise | cap_fall;
      STM_PF_CAP_OFF:  capture = 1'b0;
    endcase
    capture = capture & is_cap & run;
  end

  // PWM period and duty, in counts of the 17-bit span
  always_comb
  begin
    duty_val   = {1'b0, compare_a_value};
    period_val = {1'b0, compare_a_value};
    if (!ctrl_in.duty_period_swap)
    begin
      period_val = (compare_p_value_in == 8'h00) ? 17'h10000 : {1'b0, compare_p_value_in, 8'h00};
      duty_val   = {1'b0, compare_a_value};
    end
    else
    begin
      period_val = {1'b0, compare_a_value};
      duty_val   = (compare_p_value_in == 8'h00) ? 17'h10000 : {1'b0, compare_p_value_in, 8'h00};
    end
  end

  // Swap picks which comparator ends the period
  assign period_hit = ctrl_in.duty_period_swap ? match_a : match_p;
  assign pos        = {1'b0, cnt};
  assign pwm_active = (duty_val >= period_val) || (pos < duty_val);

  // Run bit: software, trigger pin and A match in single pulse
  always_comb
  begin
    next_run = run;
    if (run_set_in)
    begin
      next_run = 1'b1;
    end
    if (is_spulse && trig_rise)
    begin
      next_run = 1'b1;
    end
    if (run_clr_in)
    begin
      next_run = 1'b0;
    end
    if (is_spulse && match_a)
    begin
      next_run = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      run      <= 1'b0;
      run_prev <= 1'b0;
    end
    else
    begin
      run      <= next_run;
      run_prev <= run;
    end
  end

  // Counter: zeroed on run rising or on the mode's clearing match, else counts while running
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      cnt <= STM_CNT_RST;
    end
    else if (run_rise)
    begin
      cnt <= STM_CNT_RST;
    end
    else if (run)
    begin
      if (is_spulse)
      begin
        cnt <= cnt + 16'h0001;
      end
      else if (is_cap && match_p)
      begin
        cnt <= STM_CNT_RST;
      end
      else if (is_pwm && period_hit)
      begin
        cnt <= STM_CNT_RST;
      end
      else if (is_cmp && (ctrl_in.clear_source_select ? match_a : match_p))
      begin
        cnt <= STM_CNT_RST;
      end
      else
      begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // Compare A: software write, or captured counter
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      compare_a_value <= STM_COMPARE_A_VALUE_RST;
    end
    else if (capture)
    begin
      compare_a_value <= cnt;
    end
    else if (compare_a_wr_in)
    begin
      compare_a_value <= compare_a_value_in;
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end
    else
    begin
      if ((match_a && !is_cap) || capture)
      begin
        flag_a <= 1'b1;
      end
      else if (flag_a_clr_in)
      begin
        flag_a <= 1'b0;
      end
      if (match_p && !is_spulse && !(is_cmp && ctrl_in.clear_source_select))
      begin
        flag_p <= 1'b1;
      end
      else if (flag_p_clr_in)
      begin
        flag_p <= 1'b0;
      end
    end
  end

  // Waveform before the invert stage
  assign active_lvl = ctrl_in.output_level_ctrl;
  always_comb
  begin
    next_out = wave;
    if (is_pwm)
    begin
      unique case (ctrl_in.pin_function)
        STM_PF_INACT:  next_out = ~active_lvl;
        STM_PF_ACT:    next_out = active_lvl;
        STM_PF_PWM:    next_out = (run && pwm_active) ? active_lvl : ~active_lvl;
        STM_PF_SPULSE: next_out = ~active_lvl;
      endcase
    end
    else if (is_spulse)
    begin
      next_out = next_run ? active_lvl : ~active_lvl;
    end
    else if (run_rise)
    begin
      next_out = active_lvl;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      wave <= 1'b0;
    end
    else
    begin
      wave <= next_out;
    end
  end

  // Output pin; released in timer/counter mode and capture mode
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      timer_out      <= 1'b0;
      timer_oe_n_out <= 1'b1;
    end
    else
    begin
      timer_out      <= next_out ^ ctrl_in.output_invert;
      timer_oe_n_out <= (ctrl_in.mode_select == STM_MODE_TMR) || is_cap;
    end
  end

  assign counter_run_out     = run;
  assign counter_out         = cnt;
  assign compare_a_value_out = compare_a_value;
  assign match_a_flag_out    = flag_a;
  assign match_p_flag_out    = flag_p;
endmodule

/* dv/stm_timer_checker.sv */
// Port checker for the standard timer, bound to its top module.
`timescale 1ns/1ns
module stm_timer_checker
  import stm_pkg::*;
#(
  parameter int CNT_W = STM_CNT_W
)
(
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire stm_ctrl_t   ctrl_in,
  input wire logic [7:0]  compare_p_value_in,
  input wire logic        flag_a_clr_in,
  input wire logic        counter_run_out,
  input wire logic [15:0] counter_out,
  input wire logic [15:0] compare_a_value_out,
  input wire logic        match_a_flag_out,
  input wire logic        match_p_flag_out,
  input wire logic        timer_out,
  input wire logic        timer_oe_n_out
);
  // One clock domain; reset masks every check
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire logic pwm = ctrl_in.mode_select == STM_MODE_PWM;

  a_stop_hold: assert property (!counter_run_out && !$past(counter_run_out) |-> $stable(counter_out))
    else $error("counter moved while stopped");
  a_count_step: assert property (counter_run_out && $past(counter_run_out) && counter_out != 16'h0000
    |-> counter_out == $past(counter_out) + 16'h0001) else $error("counter did not step by one");
  a_run_zero: assert property ($rose(counter_run_out) |=> counter_out == 16'h0000)
    else $error("counter not zeroed on start");
  a_flag_sticky: assert property (match_a_flag_out && !flag_a_clr_in |=> match_a_flag_out)
    else $error("A flag dropped without clear");
  a_tmr_released: assert property (ctrl_in.mode_select == STM_MODE_TMR && $stable(ctrl_in) |-> timer_oe_n_out)
    else $error("pin driven in timer mode");
  // Forced level must hold while the counter keeps running underneath
  a_pwm_forced: assert property (pwm && ctrl_in.pin_function == STM_PF_INACT && $stable(ctrl_in)
    |=> timer_out == (!$past(ctrl_in.output_level_ctrl) ^ $past(ctrl_in.output_invert))) else $error("forced level wrong");
  a_no_p_flag: assert property (ctrl_in.mode_select[0] == ctrl_in.mode_select[1] && ctrl_in.clear_source_select
    && $stable(ctrl_in) && !match_p_flag_out |=> !match_p_flag_out) else $error("P flag with clear on A");
  a_pulse_end: assert property (pwm && ctrl_in.pin_function == STM_PF_SPULSE && counter_run_out
    && $past(counter_run_out) && counter_out == compare_a_value_out - 16'h0001
    |-> ##[1:2] (!counter_run_out && match_a_flag_out)) else $error("pulse not ended");
  a_cap_wrap: assert property (ctrl_in.mode_select == STM_MODE_CAP && counter_run_out
    && $past(counter_run_out) && counter_out == {compare_p_value_in - 8'h01, 8'hff}
    |=> counter_out == 16'h0000 ##[0:1] match_p_flag_out) else $error("capture wrap wrong");
endmodule

bind stm_timer stm_timer_checker #(.CNT_W(CNT_W)) u_chk
(
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ctrl_in(ctrl_in), .compare_p_value_in(compare_p_value_in),
  .flag_a_clr_in(flag_a_clr_in), .counter_run_out(counter_run_out), .counter_out(counter_out),
  .compare_a_value_out(compare_a_value_out), .match_a_flag_out(match_a_flag_out),
  .match_p_flag_out(match_p_flag_out), .timer_out(timer_out), .timer_oe_n_out(timer_oe_n_out)
);

/* dv/stm_pin_model.sv */
// Pin-side model: trigger source and capture signal source.
`timescale 1ns/1ns
module stm_pin_model
(
  input  wire logic clk_sys_in,
  input  wire logic trig_req_in,
  input  wire logic cap_level_in,
  output logic      trig_pin_out,
  output logic      cap_pin_out
);
  logic [1:0] hold = 2'h0;
  // Trigger held three clocks so the synchroniser cannot miss it
  always_ff @(posedge clk_sys_in)
  begin
    if (trig_req_in)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end
  assign trig_pin_out = hold != 2'h0;
  // Capture line lags the request, unrelated to the clock edge; unknown for the first 3 ns
  assign #3 cap_pin_out = cap_level_in;
endmodule

/* dv/standard_timer_mode_logic_bench.sv */
// Self-checking bench for the standard timer modes.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module standard_timer_mode_logic_bench
  import stm_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  stm_ctrl_t   ctrl = '0;
  logic        run_set = 1'b0;
  logic        run_clr = 1'b0;
  logic [15:0] a_val = 16'h0000;
  logic        a_wr = 1'b0;
  logic [7:0]  p_val = 8'h00;
  logic        clr_f = 1'b0;
  logic        trig_req = 1'b0;
  logic        cap_lvl = 1'b0;
  wire logic   trig_pin, cap_pin, run, fa, fp, t_out, oe_n;
  wire logic [15:0] cnt, compare_a_value;
  int          n_mismatch = 0;
  int          compares = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  stm_timer dut
  (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ctrl_in(ctrl), .run_set_in(run_set), .run_clr_in(run_clr),
    .compare_a_value_in(a_val), .compare_a_wr_in(a_wr), .compare_p_value_in(p_val), .flag_a_clr_in(clr_f),
    .flag_p_clr_in(clr_f), .ext_clock_trigger_pin_in(trig_pin), .capture_input_pin_in(cap_pin),
    .counter_run_out(run), .counter_out(cnt), .compare_a_value_out(compare_a_value), .match_a_flag_out(fa),
    .match_p_flag_out(fp), .timer_out(t_out), .timer_oe_n_out(oe_n)
  );
  stm_pin_model pins
  (
    .clk_sys_in(clk_sys_in), .trig_req_in(trig_req), .cap_level_in(cap_lvl), .trig_pin_out(trig_pin),
    .cap_pin_out(cap_pin)
  );

  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Stop first: mode and pin function may only change while stopped
  task automatic setup(input stm_ctrl_t c, input logic [15:0] a, input logic [7:0] p);
    run_clr = 1'b1;
    step(1);
    {run_clr, ctrl, a_val, p_val, a_wr, clr_f} = {1'b0, c, a, p, 2'h3};
    step(1);
    {a_wr, clr_f} = 2'h0;
  endtask
  task automatic go();
    run_set = 1'b1;
    step(1);
    run_set = 1'b0;
  endtask
  task automatic count_high(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      step(1);
      k += (t_out === 1'b1);
    end
  endtask

  task automatic test_timer();
    logic [15:0] held;
    setup('{STM_MODE_TMR, STM_PF_INACT, 1'b0, 1'b0, 1'b0, 1'b1}, 16'h0200, 8'h01);
    go();
    step(600);
    `CHK({oe_n, fa, fp}, 3'h6)
    `CHK(cnt <= 16'h0200, 1'b1)
    run_clr = 1'b1;
    step(2);
    run_clr = 1'b0;
    held = cnt;
    step(5);
    `CHK(cnt, held)
    $display("timer test done");
  endtask

  task automatic test_pwm();
    int k;
    setup('{STM_MODE_PWM, STM_PF_PWM, 1'b1, 1'b0, 1'b0, 1'b1}, 16'h0040, 8'h01);
    go();
    step(20);
    count_high(256, k);
    `CHK(k, 64)
    `CHK({oe_n, fa, fp}, 3'h3)
    setup('{STM_MODE_PWM, STM_PF_PWM, 1'b0, 1'b1, 1'b1, 1'b0}, 16'h0300, 8'h01);
    go();
    step(20);
    count_high(768, k);
    `CHK(k, 256)
    setup('{STM_MODE_PWM, STM_PF_PWM, 1'b1, 1'b0, 1'b0, 1'b0}, 16'h0200, 8'h01);
    go();
    count_high(200, k);
    `CHK(k, 200)
    setup('{STM_MODE_PWM, STM_PF_INACT, 1'b0, 1'b0, 1'b0, 1'b0}, 16'h0010, 8'h01);
    go();
    count_high(50, k);
    `CHK({k, cnt > 16'h0020}, {32'd50, 1'b1})
    $display("pwm test done");
  endtask

  task automatic test_pulse();
    int i;
    setup('{STM_MODE_PWM, STM_PF_SPULSE, 1'b1, 1'b0, 1'b1, 1'b1}, 16'h0014, 8'h01);
    trig_req = 1'b1;
    step(1);
    trig_req = 1'b0;
    for (i = 0; i < 10 && run !== 1'b1; i++) step(1);
    step(3);
    `CHK({run, t_out}, 2'h3)
    for (i = 0; i < 40 && run !== 1'b0; i++) step(1);
    step(3);
    `CHK({run, t_out, fa, fp}, 4'h2)
    go();
    step(4);
    `CHK(t_out, 1'b1)
    run_clr = 1'b1;
    step(1);
    run_clr = 1'b0;
    step(3);
    `CHK(t_out, 1'b0)
    $display("pulse test done");
  endtask

  task automatic test_capture();
    logic [1:0]  pf [5] = '{STM_PF_CAP_RISE, STM_PF_CAP_RISE, STM_PF_CAP_FALL, STM_PF_CAP_BOTH, STM_PF_CAP_OFF};
    logic        lvl [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic        hit [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] v;
    for (int j = 0; j < 5; j++)
    begin
      cap_lvl = !lvl[j];
      step(6);
      setup('{STM_MODE_CAP, pf[j], 1'b0, 1'b0, 1'b0, 1'b0}, 16'h0000, 8'h01);
      go();
      step(30);
      `CHK(cnt, 16'h001d)
      v = cnt;
      cap_lvl = lvl[j];
      step(8);
      `CHK(fa, hit[j])
      `CHK((compare_a_value >= v + 16'h0002) && (compare_a_value <= v + 16'h0006), hit[j])
    end
    step(260);
    `CHK(fp, 1'b1)
    $display("capture test done");
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence after six reset cycles
  initial
  begin
    step(6);
    sys_rst_in = 1'b0;
    step(1);
    test_timer();
    test_pwm();
    test_pulse();
    test_capture();
    report_and_stop();
  end

  // Watchdog well beyond the expected run of a few thousand cycles
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
